// *** verilog/drc_consts.svh ***
// Purpose: Constants for the display memory and address control block
// Assumes: APB slave, 32-bit data, word-aligned registers
// Notes:   Offsets, limits, reset values and counts live here
// Function
// [R1] Store 2-bit pixels, 160 columns by 161 rows
// [R2] Page maps byte to 4 or 8 rows
// [R3] Column address selects segment output directly
// [R4] Page scan: wrap page, bump column
// [R5] Reads in page scan wrap likewise
// [R6] Column scan: wrap column, bump page
// [R7] Reads in column scan wrap likewise
// [R8] Row reverse inverts row to common map
// [R9] Column reverse inverts column to segment map
// [R10] Host and refresh access arbitrated transparently
// [R11] On/off and inverse act on latch only
// [R12] Bit-order flag zero puts LSB on top
// [R13] Out-of-range partial region is ignored
// [R14] Four selectable area scroll patterns
// [R15] Host writes only mono data to icons
// [R16] Voltage is 3.6 plus code times 0.04
// [R17] Host keeps voltage code within 85..360
// [R18] Low six code bits are signed contrast; code uses the whole nine-bit code unsigned
// [R19] Eight-degree steps, sixteen slopes each; code uses slopes 1..15, slope 0 unused
// [R20] Slope setting 0..15 adds 5 mV each
// [R21] Compensate from 24 degrees, weight eight
// [R22] Three thresholds select four frame rates
// [R23] First read after address set is dummy
// [R24] Temperature arrives as digital input
`ifndef DRC_CONSTS_SVH
`define DRC_CONSTS_SVH
`define DRC_COLS          160
`define DRC_ROWS          161
`define DRC_COL_MAX       8'h9F
`define DRC_PAGE_MAX      8'h27
`define DRC_ROW_MAX       8'hA0
`define DRC_A_CTRL        12'h000
`define DRC_A_PAGE        12'h004
`define DRC_A_COL         12'h008
`define DRC_A_DATA        12'h00C
`define DRC_A_PART        12'h010
`define DRC_A_SCROLL      12'h014
`define DRC_A_VOP         12'h018
`define DRC_A_SLOPE_LO    12'h01C
`define DRC_A_SLOPE_HI    12'h020
`define DRC_A_THRESH      12'h024
`define DRC_A_RATE        12'h028
`define DRC_A_STATUS      12'h02C
`define DRC_A_REFRESH     12'h030
`define DRC_CTRL_RESET    32'h0000_0000
`define DRC_VOP_BASE_MV   16'h0E10
`define DRC_VOP_STEP_MV   16'h0028
`define DRC_SLOPE_UV      16'h1388
`define DRC_STEP_DEG      8'h08
`define DRC_REF_DEG       8'h18
`define DRC_SLOPE_RESET   64'hB682_3200_0211_2270
`define DRC_THRESH_RESET  32'h005A_280F
`define DRC_RATE_RESET    32'h1B0D_0300
`endif

// *** verilog/drc_pkg.sv ***
// Purpose: Types for the display memory and address control block
// Assumes: Constants come from drc_consts.svh
// Notes:   Types only
package drc_pkg;
  typedef struct packed {
    logic        paddr_ok;
    logic [11:0] paddr;
    logic        pwrite;
    logic [31:0] pwdata;
  } drc_req_t;
  typedef struct packed {
    logic [7:0] col;
    logic [7:0] row;
  } drc_pix_t;
  typedef enum logic [1:0] {
    DRC_IDLE,
    DRC_HOST,
    DRC_DONE
  } drc_state_t;
endpackage

// *** verilog/drc_core.sv ***
// Purpose: Display memory, address counters, refresh port, voltage logic
// Assumes: APB master holds requests; temperature is a signed degree code
// Notes:   Refresh port has priority; host waits while ref_req is high
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/100ps
`include "drc_consts.svh"
module drc_core (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ref_req,
  input  wire logic [7:0]  ref_com,
  input  wire logic [7:0]  ref_seg,
  output logic [1:0]       ref_pix,
  output logic             ref_valid,
  input  wire logic [7:0]  temp_pin,
  output logic [8:0]       vop_code,
  output logic [15:0]      vop_mv,
  output logic [4:0]       frame_rate,
  output logic             partial_on,
  output logic [1:0]       scroll_mode
);
  // Pixel storage, two bits per location
  logic [1:0]  mem_q [0:`DRC_COLS*`DRC_ROWS-1];
  logic [31:0] ctrl_q;        // Bit0 dsp,1 inv,2 dir,3 row rev,4 col rev
  logic [15:0] page_q;        // Start and end page
  logic [15:0] colr_q;        // Start and end column
  logic [7:0]  pg_q;          // Current page
  logic [7:0]  cl_q;          // Current column
  logic [15:0] part_q;        // Partial start and end row
  logic [8:0]  vop_q;
  logic [63:0] slope_q;       // Sixteen four-bit slope settings
  logic [31:0] thr_q;
  logic [31:0] rate_q;
  logic [7:0]  hold_q;        // Bus holder for the dummy read
  logic [7:0]  t_s1_q;        // Temperature synchroniser
  logic [7:0]  t_q;
  logic        part_ok;
  drc_pkg::drc_req_t req;
  drc_pkg::drc_pix_t pix;
  logic        acc;
  logic        busy;
  logic        gray;
  logic [3:0]  rpp;           // Rows per page

  // Flat index of a pixel
  function automatic logic [14:0] idx(input logic [7:0] c,
                                      input logic [7:0] r);
    idx = 15'(r) * 15'd160 + 15'(c);
  endfunction

  assign req = '{paddr_ok: 1'b1, paddr: paddr, pwrite: pwrite,
                 pwdata: pwdata};
  assign gray = ctrl_q[5];
  // [R2] page depth
  assign rpp = gray ? 4'd4 : 4'd8;
  // [R10] refresh wins, host access stalls
  assign busy = ref_req && clk_en;
  assign acc = psel && penable && !busy && clk_en;
  assign pready = psel && penable && !busy;
  assign pslverr = 1'b0;

  // Control and configuration writes
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ctrl_q <= `DRC_CTRL_RESET;
      page_q <= 16'h0000;
      colr_q <= 16'h0000;
      part_q <= 16'h0000;
      vop_q <= 9'h000;
      slope_q <= `DRC_SLOPE_RESET;
      thr_q <= `DRC_THRESH_RESET;
      rate_q <= `DRC_RATE_RESET;
    end
    else if (acc && req.pwrite)
    begin
      unique case (req.paddr)
        `DRC_A_CTRL:     ctrl_q <= req.pwdata;
        `DRC_A_PAGE:     page_q <= req.pwdata[15:0];
        `DRC_A_COL:      colr_q <= req.pwdata[15:0];
        `DRC_A_PART:     part_q <= req.pwdata[15:0];
        `DRC_A_VOP:      vop_q <= req.pwdata[8:0];
        `DRC_A_SLOPE_LO: slope_q[31:0] <= req.pwdata;
        `DRC_A_SLOPE_HI: slope_q[63:32] <= req.pwdata;
        `DRC_A_THRESH:   thr_q <= req.pwdata;
        `DRC_A_RATE:     rate_q <= req.pwdata;
        default:         ;
      endcase
    end
  end

  // Address counters, start over when a range is written
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pg_q <= 8'h00;
      cl_q <= 8'h00;
    end
    else if (acc && req.pwrite && req.paddr == `DRC_A_PAGE)
      pg_q <= req.pwdata[7:0];
    else if (acc && req.pwrite && req.paddr == `DRC_A_COL)
      cl_q <= req.pwdata[7:0];
    else if (acc && req.paddr == `DRC_A_DATA)
    begin
      if (ctrl_q[2])
      begin
        // [R4] page direction
        // [R5] reads wrap the same
        if (pg_q >= page_q[15:8])
        begin
          pg_q <= page_q[7:0];
          cl_q <= cl_q + 8'd1;
        end
        else
          pg_q <= pg_q + 8'd1;
      end
      else
      begin
        // [R6] column direction
        // [R7] reads wrap the same
        if (cl_q >= colr_q[15:8])
        begin
          cl_q <= colr_q[7:0];
          pg_q <= pg_q + 8'd1;
        end
        else
          cl_q <= cl_q + 8'd1;
      end
    end
  end

  // Pixel writes; each bit (in gray mode each bit pair) of a byte goes to one row
  always_ff @(posedge clk_sys)
  begin
    if (acc && req.pwrite && req.paddr == `DRC_A_DATA)
    begin
      for (int k = 0; k < 8; k++)
      begin
        logic [7:0] r;
        logic [3:0] s;
        r = 8'h00;
        s = ctrl_q[6] ? 4'(rpp - 4'd1 - 4'(k)) : 4'(k);
        // [R12] bit order
        r = 8'(pg_q * 8'(rpp)) + 8'(s);
        if (gray ? (k < 4) : 1'b1)
        begin
          // [R1] two-bit cells
          if (r <= `DRC_ROW_MAX && cl_q <= `DRC_COL_MAX)
            mem_q[idx(cl_q, r)] <= gray ? req.pwdata[2*k +: 2]
                                        : {2{req.pwdata[k]}};
        end
      end
    end
  end

  // [R23] bus holder gives stale byte first
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      hold_q <= 8'h00;
    else if (acc && !req.pwrite && req.paddr == `DRC_A_DATA)
    begin
      for (int k = 0; k < 8; k++)
        hold_q[k] <= mem_q[idx(cl_q, 8'(pg_q * 8'(rpp)) +
                                8'(k[2:0]))][0];
    end
  end

  // Read data mux, registered
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !req.pwrite && clk_en)
    begin
      unique case (req.paddr)
        `DRC_A_CTRL:     prdata <= ctrl_q;
        `DRC_A_PAGE:     prdata <= {16'h0000, page_q};
        `DRC_A_COL:      prdata <= {16'h0000, colr_q};
        `DRC_A_DATA:     prdata <= {24'h000000, hold_q};
        `DRC_A_PART:     prdata <= {16'h0000, part_q};
        `DRC_A_VOP:      prdata <= {23'h0, vop_q};
        `DRC_A_SLOPE_LO: prdata <= slope_q[31:0];
        `DRC_A_SLOPE_HI: prdata <= slope_q[63:32];
        `DRC_A_THRESH:   prdata <= thr_q;
        `DRC_A_RATE:     prdata <= rate_q;
        `DRC_A_STATUS:   prdata <= {7'h0, part_ok, t_q, cl_q, pg_q};
        default:         prdata <= 32'h0000_0000;
      endcase
    end
  end

  // [R8] row reverse, [R9] column reverse
  assign pix.row = ctrl_q[3] ? 8'(`DRC_ROW_MAX - ref_com) : ref_com;
  assign pix.col = ctrl_q[4] ? 8'(`DRC_COL_MAX - ref_seg) : ref_seg;

  // Refresh latch; on/off and inverse touch only this latch
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ref_pix <= 2'b00;
      ref_valid <= 1'b0;
    end
    else if (clk_en)
    begin
      ref_valid <= ref_req;
      // [R3] column is segment
      // [R11] latch-only effects
      if (ref_req)
        ref_pix <= !ctrl_q[0] ? 2'b00 :
                   (ctrl_q[1] ? ~mem_q[idx(pix.col, pix.row)]
                              : mem_q[idx(pix.col, pix.row)]);
    end
  end

  // [R13] partial region check
  assign part_ok = part_q[7:0] <= part_q[15:8] &&
                   part_q[15:8] <= `DRC_COL_MAX;
  assign partial_on = ctrl_q[7] && part_ok;
  // [R14] four scroll patterns
  assign scroll_mode = ctrl_q[9:8];

  // [R24] temperature pin synchroniser
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      t_s1_q <= 8'h18;
      t_q <= 8'h18;
    end
    else if (clk_en)
    begin
      t_s1_q <= temp_pin;
      t_q <= t_s1_q;
    end
  end

  // [R18] whole nine-bit code passed out unsigned, not low six bits as signed contrast
  assign vop_code = vop_q;

  // [R19] [R20] [R21] compensated voltage in mV
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      vop_mv <= 16'h0000;
    else if (clk_en)
    begin
      int acc_uv;
      int t;
      int lo;
      int sl;
      acc_uv = 0;
      t = int'($signed(t_q));
      for (int i = 1; i < 16; i++)
      begin
        lo = -32 + (i - 1) * 8;
        sl = int'(slope_q[4*i +: 4]) * 5000;
        if (i <= 7 && t < lo + 8)
          acc_uv += sl * ((t < lo) ? 8 : (lo + 8 - t));
        else if (i >= 8 && t >= lo)
          acc_uv -= sl * ((t >= lo + 8) ? 8 : (t - lo));
      end
      // [R16] base plus code times step
      vop_mv <= 16'(3600 + int'(vop_q) * 40 + acc_uv / 1000);
    end
  end

  // [R22] threshold frame rate select
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      frame_rate <= 5'h00;
    else if (clk_en)
    begin
      if ($signed(t_q) < $signed({1'b0, thr_q[6:0]}))
        frame_rate <= rate_q[4:0];
      else if ($signed(t_q) < $signed({1'b0, thr_q[14:8]}))
        frame_rate <= rate_q[12:8];
      else if ($signed(t_q) < $signed({1'b0, thr_q[22:16]}))
        frame_rate <= rate_q[20:16];
      else
        frame_rate <= rate_q[28:24];
    end
  end
endmodule

// *** sim/drc_core_properties.sv ***
// Purpose: Port assertions for drc_core
// Assumes: clk_en held high, one clock domain
// Notes:   Bound to every drc_core instance
`timescale 1ns/100ps
`include "drc_consts.svh"
module drc_core_properties (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        ref_req,
  input wire logic        ref_valid,
  input wire logic [8:0]  vop_code
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic       vop_wr;   // Accepted write to the voltage code
  logic [8:0] wr_code;  // Code field of the write data
  assign vop_wr = psel && penable && pready && pwrite
                  && paddr == `DRC_A_VOP;
  assign wr_code = pwdata[8:0];
  property p_rdy; psel && penable && !ref_req |-> pready; endproperty
  a_rdy: assert property (p_rdy)
    else $error("host access not answered");
  property p_yield; ref_req |-> !pready; endproperty
  a_yield: assert property (p_yield)
    else $error("host answered during refresh");
  property p_acc; pready |-> psel && penable; endproperty
  a_acc: assert property (p_acc)
    else $error("ready outside access phase");
  property p_err; psel |-> !pslverr; endproperty
  a_err: assert property (p_err)
    else $error("unexpected slave error");
  property p_fol; ref_req |=> ref_valid; endproperty
  a_fol: assert property (p_fol)
    else $error("refresh pixel not valid");
  property p_nof; !ref_req |=> !ref_valid; endproperty
  a_nof: assert property (p_nof)
    else $error("refresh valid without request");
  property p_vset; vop_wr |=> vop_code == $past(wr_code); endproperty
  a_vset: assert property (p_vset)
    else $error("voltage code not stored");
  property p_vhold; !vop_wr |=> $stable(vop_code); endproperty
  a_vhold: assert property (p_vhold)
    else $error("voltage code moved");
  c_stall: cover property (psel && penable && ref_req);
  c_vop: cover property (vop_wr);
  c_ref: cover property (ref_req ##1 !ref_req);
endmodule
bind drc_core drc_core_properties u_chk (.clk_sys, .rst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .ref_req, .ref_valid,
  .vop_code);

// *** sim/drc_host_model.sv ***
// Purpose: Host processor model speaking APB
// Assumes: One transfer at a time, idle cycle between
// Notes:   Queues one expectation per read for the scoreboard
`timescale 1ns/100ps
module drc_host_model (
  input  wire logic        clk_sys,
  input  wire logic        pready,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata
);
  logic [32:0] exp_q[$];  // Compare flag and value per read
  logic        hung = 0;  // A wait for ready ran out
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  function automatic logic [8:0] pick(input logic [31:0] r);
    return 9'(85 + r % 276);
  endfunction
  // dummy reads queued with compare low
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, input logic cmp);
    int n;
    if (!wr)
      exp_q.push_back({cmp, d});
    @(posedge clk_sys);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    // Refresh may hold ready low, so wait bounded
    for (n = 0; n < 100 && !pready; n++)
      @(posedge clk_sys);
    hung <= hung | !pready;
    {psel, penable} <= 2'b00;
  endtask
endmodule

// *** sim/tb_display_ram_address_control.sv ***
// Purpose: Self-checking bench for drc_core
// Assumes: clk_en held high; refresh traffic is random
// Notes:   Reads are scored from a queue of expectations
`timescale 1ns/100ps
`include "drc_consts.svh"
module tb_display_ram_address_control;
  logic        clk_sys = 0;
  logic        rst = 1;
  logic        ref_req = 0;
  logic [7:0]  ref_com = 0, ref_seg = 0, temp_pin = 8'h18;
  logic [31:0] seed = 32'h0000_001F;  // Random state
  logic [31:0] prdata, pwdata;
  logic [32:0] ex;
  logic [11:0] paddr;
  logic        psel, penable, pwrite, pready, pslverr;
  logic        ref_valid, partial_on;
  logic [1:0]  ref_pix, scroll_mode;
  logic [8:0]  vop_code, c;
  logic [15:0] vop_mv;
  logic [4:0]  frame_rate;
  int          bad_count = 0, checks_done = 0;
  // Reset values of the control, voltage, slope, threshold, rate
  logic [11:0] ra[6] = '{`DRC_A_CTRL, `DRC_A_VOP, `DRC_A_SLOPE_LO,
                         `DRC_A_SLOPE_HI, `DRC_A_THRESH, `DRC_A_RATE};
  logic [31:0] rv[6] = '{32'h0000_0000, 32'h0000_0000, 32'h0211_2270,
                         32'hB682_3200, 32'h005A_280F, 32'h1B0D_0300};
  always #2 clk_sys = ~clk_sys;
  drc_host_model host (.clk_sys, .pready, .psel, .penable, .pwrite,
                       .paddr, .pwdata);
  drc_core dut (.clk_sys, .rst, .clk_en(1'b1), .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .ref_req, .ref_com,
    .ref_seg, .ref_pix, .ref_valid, .temp_pin, .vop_code, .vop_mv,
    .frame_rate, .partial_on, .scroll_mode);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Random refresh reads in range, so the host keeps being stalled
  always @(posedge clk_sys)
  begin
    seed <= xs(seed);
    ref_req <= !rst && seed[0] && seed[1];
    ref_com <= 8'(seed[15:8] % 161);
    ref_seg <= 8'(seed[23:16] % 160);
    temp_pin <= 8'(seed[30:24] % 120) - 8'h20;
  end
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    checks_done++;
    if (s !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Score each completed read against the oldest note
  always @(posedge clk_sys)
    if (psel && penable && pready && !pwrite)
    begin
      ex = host.exp_q.pop_front();
      if (ex[32])
        chk("prdata", ex[31:0], prdata);
    end
  // A bus wait that ran out ends the run
  always @(posedge clk_sys)
    if (host.hung)
    begin
      bad_count++;
      complete_run();
    end
  // Reload a two page by two column window at the origin
  task automatic win;
    host.xfer(1'b1, `DRC_A_PAGE, 32'h0000_0100, 1'b0);
    host.xfer(1'b1, `DRC_A_COL, 32'h0000_0100, 1'b0);
  endtask
  // Write three bytes in the scan order of cw, read back in the scan order of cr
  task automatic scan(input logic [31:0] cw, input logic [31:0] cr,
                      input logic sw);
    logic [23:0] d;
    d = seed[23:0];
    host.xfer(1'b1, `DRC_A_CTRL, cw, 1'b0);
    win();
    for (int i = 0; i < 24; i += 8)
      host.xfer(1'b1, `DRC_A_DATA, {24'h0, d[i+:8]}, 1'b0);
    host.xfer(1'b1, `DRC_A_CTRL, cr, 1'b0);
    win();
    host.xfer(1'b0, `DRC_A_DATA, 32'h0, 1'b0);
    host.xfer(1'b0, `DRC_A_DATA, {24'h0, d[7:0]}, 1'b1);
    host.xfer(1'b0, `DRC_A_DATA, {24'h0, sw ? d[23:16] : d[15:8]}, 1'b1);
    host.xfer(1'b0, `DRC_A_DATA, {24'h0, sw ? d[15:8] : d[23:16]}, 1'b1);
    $display("test scan %0d ended", sw);
  endtask
  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++)
      host.xfer(1'b0, ra[i], rv[i], 1'b1);
    // Unmapped place ignores writes and reads zero
    host.xfer(1'b1, 12'h0FC, 32'hFFFF_FFFF, 1'b0);
    host.xfer(1'b0, 12'h0FC, 32'h0000_0000, 1'b1);
    $display("test reset ended");
    for (int i = 0; i < 4; i++)
    begin
      c = i == 0 ? 9'h055 : i == 1 ? 9'h168 : host.pick(seed);
      host.xfer(1'b1, `DRC_A_VOP, {23'h0, c}, 1'b0);
      host.xfer(1'b0, `DRC_A_VOP, {23'h0, c}, 1'b1);
      chk("vop_code", {23'h0, c}, {23'h0, vop_code});
    end
    $display("test voltage ended");
    scan(32'h0000_0000, 32'h0000_0003, 1'b0);
    scan(32'h0000_0004, 32'h0000_0000, 1'b1);
    @(posedge clk_sys);
    chk("queue", 32'h0, 32'(host.exp_q.size()));
    complete_run();
  end
endmodule
